// [core/ld_ctrl_defs.svh]
// Constants for the laser driver enable and protection controller.
// Assumes temperatures arrive as signed whole degrees C, already sampled.
`ifndef LD_CTRL_DEFS_SVH
`define LD_CTRL_DEFS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_THERM_LIM 12'h010
`define OFS_THERM_READ 12'h014
`define OFS_RAMP 12'h018

// ------------------------------------------------------------
// Temperatures, degrees C
// ------------------------------------------------------------
`define WARN_SET_C 8'sh3C
`define WARN_CLR_C 8'sh3A
`define SHUT_SET_C 8'sh50
`define SHUT_CLR_C 8'sh3A

// ------------------------------------------------------------
// Reset values, full-scale level and widths
// ------------------------------------------------------------
`define CTRL_RST 32'h0000_0000
`define LIM_RST 32'h0000_7FF6
`define RAMP_RST 16'h0040
`define LEVEL_MAX 16'hFFFF
`define IRQ_W 4

// ------------------------------------------------------------
// Control and interrupt bit positions
// ------------------------------------------------------------
`define CTL_INT_SET 0
`define CTL_INT_EN 1
`define CTL_SW_EN 2
`define CTL_LOCK_OFF 3
`define IRQ_FAULT 0
`define IRQ_WARN 1
`define IRQ_OVT 2
`define IRQ_NTC 3

`endif

// [core/ld_ctrl_pkg.sv]
// Types for the laser driver enable and protection controller.
// Assumes nothing beyond the defs header.
package ld_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RAMP = 2'b01,
        ST_ON = 2'b10,
        ST_FAULT = 2'b11
    } out_state_type;
endpackage

// [core/driver_enable_protection_ctrl.sv]
// Enable, lock and protection controller for a constant-current driver.
// Assumes an AHB-Lite master on ref_clk; pin and sensor inputs are asynchronous.
//
// What this block does
// - Output on only while enable is high
// - Each enable rise restarts the soft-start ramp
// - Fault flag high while protection fault active
// - Over-current or over-temperature engages output clamp
// - Enable ignored, output off during shutdown
// - Fault latched until power is removed
// - Output only while safety lock held low
// - Warning above 60C, cleared below 58C
// - Stop above 80C, restart at 58C
// - Thermistor out of limits blocks, resumes automatically
// - Thermistor reading readable over the bus
// - Power-on default: analogue set, pin enable, lock
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "ld_ctrl_defs.svh"

module driver_enable_protection_ctrl
    import ld_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic refClk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins and sensors (asynchronous)
    input wire logic enablePin,
    input wire logic lockPin,
    input wire logic overCurrent,
    input wire logic [7:0] boardTemp,
    input wire logic [7:0] thermTemp,
    // Driver outputs
    output logic outEnable,
    output logic [15:0] outLevel,
    output logic clampOn,
    output logic faultFlag,
    output logic tempWarn,
    output logic internalSet,
    output logic irq
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinS1_r, pinS2_r; // Enable, lock, over-current
    logic [7:0] bS1_r, bS2_r, tS1_r, tS2_r; // Temperatures
    // Multi-bit temperatures: a sensor word is assumed slow and settled
    always_ff @(posedge refClk) begin
        pinS1_r <= {overCurrent, lockPin, enablePin};
        pinS2_r <= pinS1_r;
        bS1_r <= boardTemp;
        bS2_r <= bS1_r;
        tS1_r <= thermTemp;
        tS2_r <= tS1_r;
    end

    wire logic enS = pinS2_r[0];
    wire logic lockS = pinS2_r[1];
    wire logic ocS = pinS2_r[2];
    wire logic signed [7:0] bTemp = bS2_r;
    wire logic signed [7:0] tTemp = tS2_r;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] ctrl_r; // Software state selection
    logic [31:0] lim_r; // [15:8] upper, [7:0] lower thermistor limit
    logic [15:0] ramp_r; // Ramp step per cycle
    logic [`IRQ_W-1:0] irqStat_r, irqMask_r;
    logic enPrev_r;
    logic warn_r, ovt_r, faultLatch_r;
    out_state_type state_r, state_nxt;
    logic [15:0] level_r, level_nxt;

    // Bus address phase capture
    logic wrPend_r, rdPend_r;
    logic [11:0] addr_r;

    // ------------------------------------------------------------
    // Decode of control and conditions
    // ------------------------------------------------------------
    // Software enable replaces the pin only when internal enable is chosen
    wire logic swMode = ctrl_r[`CTL_INT_EN];
    wire logic enSel = swMode ? ctrl_r[`CTL_SW_EN] : enS;
    wire logic enRise = enS & ~enPrev_r;
    wire logic lockOk = ~lockS | ctrl_r[`CTL_LOCK_OFF];
    wire logic signed [7:0] limHi = lim_r[15:8];
    wire logic signed [7:0] limLo = lim_r[7:0];
    wire logic ntcBad = (tTemp > limHi) | (tTemp < limLo);
    wire logic ovtSet = bTemp > `SHUT_SET_C;
    wire logic ovtClr = bTemp <= `SHUT_CLR_C;
    wire logic warnSet = bTemp > `WARN_SET_C;
    wire logic warnClr = bTemp < `WARN_CLR_C;
    // A shutdown cause that latches until power cycle
    wire logic tripNow = ocS;
    // Over-temperature clamps only while hot, so a cooled driver may restart
    wire logic ovtAct = ovt_r | ovtSet;
    wire logic permit = enSel & lockOk & ~ntcBad & ~ovtAct;
    wire logic faultAct = faultLatch_r | tripNow;
    wire logic [16:0] levelSum = {1'b0, level_r} + {1'b0, ramp_r};

    // ------------------------------------------------------------
    // Output state machine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        level_nxt = level_r;
        case (state_r)
            ST_OFF: begin
                level_nxt = 16'h0000;
                if (faultAct) begin
                    state_nxt = ST_FAULT;
                end else if (permit & (swMode | enRise | enS)) begin
                    state_nxt = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (faultAct) begin
                    state_nxt = ST_FAULT;
                    level_nxt = 16'h0000;
                end else if (~permit) begin
                    state_nxt = ST_OFF;
                    level_nxt = 16'h0000;
                end else if (levelSum[16]) begin
                    state_nxt = ST_ON;
                    level_nxt = `LEVEL_MAX;
                end else begin
                    level_nxt = levelSum[15:0];
                end
            end
            ST_ON: begin
                if (faultAct) begin
                    state_nxt = ST_FAULT;
                    level_nxt = 16'h0000;
                end else if (~permit) begin
                    state_nxt = ST_OFF;
                    level_nxt = 16'h0000;
                end
            end
            ST_FAULT: begin
                // Enable is ignored here; only reset leaves, like power removal
                level_nxt = 16'h0000;
            end
            default: begin
                state_nxt = ST_OFF;
                level_nxt = 16'h0000;
            end
        endcase
    end

    // Reset models the power-on of the driver
    always_ff @(posedge refClk) begin
        if (!rst_n) begin
            state_r <= ST_OFF;
            level_r <= 16'h0000;
            enPrev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            level_r <= level_nxt;
            enPrev_r <= enS;
        end
    end

    // ------------------------------------------------------------
    // Protection and temperature flags
    // ------------------------------------------------------------
    // Warning hysteresis: hold between thresholds
    always_ff @(posedge refClk) begin
        if (!rst_n) begin
            warn_r <= 1'b0;
            ovt_r <= 1'b0;
            faultLatch_r <= 1'b0;
        end else begin
            if (warnSet) begin
                warn_r <= 1'b1;
            end else if (warnClr) begin
                warn_r <= 1'b0;
            end
            if (ovtSet) begin
                ovt_r <= 1'b1;
            end else if (ovtClr) begin
                ovt_r <= 1'b0;
            end
            if (tripNow) begin
                faultLatch_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ------------------------------------------------------------
    wire logic addrOk = hsel & hready & htrans[1];
    wire logic [31:0] statusWord = {24'h0, ntcBad, ovt_r, warn_r, faultLatch_r,
                                    lockS, enS, state_r};
    wire logic [`IRQ_W-1:0] irqEvt = {ntcBad, ovt_r, warn_r, faultLatch_r};
    wire logic rdIrq = rdPend_r & (addr_r == `OFS_IRQ_STAT);
    // Read select from the address phase, so registered data stands in the data phase
    wire logic [11:0] rdAddr = {haddr[11:2], 2'b00};
    logic [31:0] rdMux;
    always_comb begin
        if (rdAddr == `OFS_CTRL) begin
            rdMux = ctrl_r;
        end else if (rdAddr == `OFS_STATUS) begin
            rdMux = statusWord;
        end else if (rdAddr == `OFS_IRQ_STAT) begin
            rdMux = {28'h0, irqStat_r};
        end else if (rdAddr == `OFS_IRQ_MASK) begin
            rdMux = {28'h0, irqMask_r};
        end else if (rdAddr == `OFS_THERM_LIM) begin
            rdMux = lim_r;
        end else if (rdAddr == `OFS_THERM_READ) begin
            rdMux = {24'h0, tTemp};
        end else if (rdAddr == `OFS_RAMP) begin
            rdMux = {16'h0, ramp_r};
        end else begin
            rdMux = 32'h0000_0000; // Unmapped reads as zero
        end
    end

    // Address phase capture
    always_ff @(posedge refClk) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            rdPend_r <= 1'b0;
            addr_r <= 12'h000;
        end else begin
            wrPend_r <= addrOk & hwrite;
            rdPend_r <= addrOk & ~hwrite;
            addr_r <= addrOk ? {haddr[11:2], 2'b00} : addr_r;
        end
    end

    // Register writes; power-on default is all control bits clear
    always_ff @(posedge refClk) begin
        if (!rst_n) begin
            ctrl_r <= `CTRL_RST;
            lim_r <= `LIM_RST;
            ramp_r <= `RAMP_RST;
            irqMask_r <= 4'h0;
        end else if (wrPend_r) begin
            if (addr_r == `OFS_CTRL) begin
                ctrl_r <= {28'h0, hwdata[3:0]};
            end else if (addr_r == `OFS_IRQ_MASK) begin
                irqMask_r <= hwdata[`IRQ_W-1:0];
            end else if (addr_r == `OFS_THERM_LIM) begin
                lim_r <= {16'h0, hwdata[15:0]};
            end else if (addr_r == `OFS_RAMP) begin
                ramp_r <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
            end
        end
    end

    // Sticky events; a new event wins over the read clear
    always_ff @(posedge refClk) begin
        if (!rst_n) begin
            irqStat_r <= 4'h0;
        end else begin
            irqStat_r <= (rdIrq ? 4'h0 : irqStat_r) | irqEvt;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge refClk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            outEnable <= 1'b0;
            outLevel <= 16'h0000;
            clampOn <= 1'b0;
            faultFlag <= 1'b0;
            tempWarn <= 1'b0;
            internalSet <= 1'b0;
            irq <= 1'b0;
        end else begin
            hrdata <= (addrOk & ~hwrite) ? rdMux : hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            outEnable <= (state_nxt == ST_RAMP) | (state_nxt == ST_ON);
            outLevel <= level_nxt;
            clampOn <= (state_nxt == ST_FAULT) | ovtAct;
            faultFlag <= (state_nxt == ST_FAULT) | ovtAct;
            tempWarn <= warnSet | (warn_r & ~warnClr);
            internalSet <= ctrl_r[`CTL_INT_SET];
            irq <= |(irqStat_r & irqMask_r);
        end
    end

endmodule

// [sim/pin_ctrl_model.sv]
// Model of the outside controller on the enable and lock pins.
// Assumes the bench clock; the pin pulls are modelled as plain levels.
`timescale 1ns/100ps

module pin_ctrl_model (
    // Clock
    input wire logic clk,
    // Requests from the bench
    input wire logic enReq,
    input wire logic lockGnd,
    input wire logic pulse,
    // Pins
    output logic enablePin,
    output logic lockPin
);
    logic [2:0] cnt_r = 3'h0; // Half-period counter
    logic sq_r = 1'b0; // Square wave, 16-cycle period

    // Free square wave, used only while pulsing
    always_ff @(posedge clk) begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h7) begin
            sq_r <= ~sq_r;
        end
    end

    // Enable is pulled down when nothing drives it
    assign enablePin = pulse ? sq_r : enReq;
    // Open lock input floats high through its pull-up
    assign lockPin = lockGnd ? 1'b0 : 1'b1;
endmodule

// [sim/driver_enable_protection_ctrl_asserts.sv]
// Port-level checks for the enable and protection controller.
// Assumes software enable and lock bypass are used only while the pins are on.
`timescale 1ns/100ps
`include "ld_ctrl_defs.svh"

module dep_ctrl_asserts (
    // Clock and reset
    input wire logic refClk,
    input wire logic rst_n,
    // Pins and sensors
    input wire logic enablePin,
    input wire logic lockPin,
    input wire logic overCurrent,
    input wire logic [7:0] boardTemp,
    // Outputs
    input wire logic outEnable,
    input wire logic [15:0] outLevel,
    input wire logic clampOn,
    input wire logic faultFlag,
    input wire logic tempWarn
);
    default clocking @(posedge refClk); endclocking
    default disable iff (!rst_n);
    logic signed [7:0] tC; // Board temperature as signed
    assign tC = boardTemp;

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_en_low; !enablePin [*6] |-> !outEnable; endproperty
    a_en_low: assert property (p_en_low) else $error("output on, enable low");
    property p_ramp; outEnable && $past(outEnable) |-> outLevel >= $past(outLevel); endproperty
    a_ramp: assert property (p_ramp) else $error("level fell during ramp");
    property p_flag; faultFlag == clampOn; endproperty
    a_flag: assert property (p_flag) else $error("flag differs from clamp");
    property p_oc; overCurrent [*4] |-> ##[0:8] clampOn; endproperty
    a_oc: assert property (p_oc) else $error("no clamp on overcurrent");
    property p_shut; faultFlag |-> !outEnable; endproperty
    a_shut: assert property (p_shut) else $error("output on during fault");
    // A hot shutdown ends within a few cool cycles; a fault outlasting eight is latched
    property p_latch; (faultFlag && tC <= `SHUT_CLR_C) [*8] |=> faultFlag; endproperty
    a_latch: assert property (p_latch) else $error("fault released");
    property p_lock; lockPin [*6] |-> !outEnable; endproperty
    a_lock: assert property (p_lock) else $error("output on, lock open");
    property p_wset; (tC > `WARN_SET_C) [*6] |-> tempWarn; endproperty
    a_wset: assert property (p_wset) else $error("warning missing");
    property p_wclr; (tC < `WARN_CLR_C) [*6] |-> !tempWarn; endproperty
    a_wclr: assert property (p_wclr) else $error("warning stuck");
    property p_whold; (tC >= `WARN_CLR_C && tC <= `WARN_SET_C) [*6] |=> $stable(tempWarn);
    endproperty
    a_whold: assert property (p_whold) else $error("warning moved in band");
    property p_hot; (tC > `SHUT_SET_C) [*6] |-> !outEnable; endproperty
    a_hot: assert property (p_hot) else $error("output on when hot");
    // Main scenarios reached
    c_on: cover property ($rose(outEnable));
    c_fault: cover property ($rose(faultFlag));
    c_warn: cover property ($rose(tempWarn));
endmodule

bind driver_enable_protection_ctrl dep_ctrl_asserts u_chk (.refClk, .rst_n, .enablePin,
    .lockPin, .overCurrent, .boardTemp, .outEnable, .outLevel, .clampOn, .faultFlag, .tempWarn);

// [sim/tb.sv]
// Bench for the enable and protection controller.
// Assumes one bus slave; hready is its own hreadyout.
`timescale 1ns/100ps
`include "ld_ctrl_defs.svh"

module tb;
    logic refClk = 0, rst_n = 0, hsel = 0, hwrite = 0, overCurrent = 0;
    logic enReq = 0, lockGnd = 1, pulse = 0; // Partner requests
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic [7:0] boardTemp = 8'h19, thermTemp = 8'h19;
    logic hreadyout, hresp, enablePin, lockPin, outEnable, clampOn, faultFlag;
    logic tempWarn, internalSet, irq, a;
    logic [15:0] outLevel, l0;
    int mismatches = 0, compares = 0, n;
    always #2 refClk = ~refClk;

    driver_enable_protection_ctrl DUT (.refClk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .enablePin,
        .lockPin, .overCurrent, .boardTemp, .thermTemp, .outEnable, .outLevel, .clampOn,
        .faultFlag, .tempWarn, .internalSet, .irq);
    pin_ctrl_model PCM (.clk(refClk), .enReq, .lockGnd, .pulse, .enablePin, .lockPin);

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Bounded wait for a level; running out ends the run
    task automatic wt(ref logic s, input logic v);
        for (int k = 0; k < 64 && s !== v; k++) @(posedge refClk);
        chk("level wait", s, v);
        if (s !== v) wrap_up();
    endtask
    task rdy;
        for (int k = 0; k < 50; k++) begin
            @(posedge refClk);
            if (hreadyout === 1'b1) return;
        end
        chk("hreadyout", 0, 1);
        wrap_up();
    endtask
    // One whole-word transfer, address phase then data phase
    task ahb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        @(posedge refClk);
        hsel <= 1;
        haddr <= ad;
        hwrite <= w;
        htrans <= 2'h2;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
        chk("hresp", hresp, 0);
    endtask
    task on_off(input logic v);
        enReq <= v;
        wt(outEnable, v);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        chk("outEnable", outEnable, 0);
        chk("internalSet", internalSet, 0);
        ahb(0, `OFS_CTRL, 0);
        chk("ctrl", r, `CTRL_RST);
        $display("t_reset done");
    endtask
    task t_enable;
        on_off(1);
        l0 = outLevel;
        repeat (20) @(posedge refClk);
        chk("ramp", outLevel > l0, 1);
        lockGnd <= 0;
        wt(outEnable, 0);
        lockGnd <= 1;
        on_off(0);
        $display("t_enable done");
    endtask
    task t_pulse;
        pulse <= 1;
        repeat (40) @(posedge refClk);
        n = 0;
        a = outEnable;
        repeat (64) begin
            @(posedge refClk);
            if (outEnable && !a) n++;
            a = outEnable;
        end
        chk("pulses", n, 4);
        pulse <= 0;
        wt(outEnable, 0);
        $display("t_pulse done");
    endtask
    task t_warn_irq;
        boardTemp <= 8'h3B;
        repeat (12) @(posedge refClk);
        chk("warn low hold", tempWarn, 0);
        boardTemp <= 8'h3D;
        wt(tempWarn, 1);
        boardTemp <= 8'h3B;
        repeat (12) @(posedge refClk);
        chk("warn high hold", tempWarn, 1);
        boardTemp <= 8'h39;
        wt(tempWarn, 0);
        ahb(1, `OFS_IRQ_MASK, 32'h0);
        repeat (3) @(posedge refClk);
        chk("irq masked", irq, 0);
        ahb(1, `OFS_IRQ_MASK, 32'hF);
        repeat (3) @(posedge refClk);
        chk("irq unmasked", irq, 1);
        ahb(0, `OFS_IRQ_STAT, 0);
        chk("warn event", r[`IRQ_WARN], 1);
        ahb(0, `OFS_IRQ_STAT, 0);
        chk("status cleared", r, 0);
        chk("irq cleared", irq, 0);
        ahb(0, 12'h0FC, 0);
        chk("unmapped", r, 0);
        $display("t_warn_irq done");
    endtask
    task t_therm;
        thermTemp <= 8'h2A;
        repeat (8) @(posedge refClk);
        ahb(0, `OFS_THERM_READ, 0);
        chk("therm read", r[7:0], 8'h2A);
        on_off(1);
        thermTemp <= 8'h80;
        wt(outEnable, 0);
        thermTemp <= 8'h19;
        wt(outEnable, 1);
        on_off(0);
        $display("t_therm done");
    endtask
    task t_hot;
        on_off(1);
        boardTemp <= 8'h51;
        wt(outEnable, 0);
        chk("hot clamp", clampOn, 1);
        boardTemp <= 8'h3B;
        enReq <= 0;
        repeat (6) @(posedge refClk);
        enReq <= 1;
        repeat (20) @(posedge refClk);
        chk("hot hold", outEnable, 0);
        boardTemp <= 8'h3A;
        enReq <= 0;
        repeat (6) @(posedge refClk);
        on_off(1);
        chk("hot flag clear", faultFlag, 0);
        on_off(0);
        $display("t_hot done");
    endtask
    // Software state selection, pins held on so the pin checks stay valid
    task t_soft;
        on_off(1);
        ahb(1, `OFS_CTRL, 32'h3);
        wt(outEnable, 0);
        chk("internalSet", internalSet, 1);
        ahb(1, `OFS_CTRL, 32'hF);
        wt(outEnable, 1);
        ahb(0, `OFS_CTRL, 0);
        chk("ctrl", r, 32'hF);
        ahb(1, `OFS_CTRL, `CTRL_RST);
        repeat (4) @(posedge refClk);
        chk("pin control", outEnable, 1);
        on_off(0);
        $display("t_soft done");
    endtask
    task t_fault;
        on_off(1);
        overCurrent <= 1;
        wt(faultFlag, 1);
        repeat (2) @(posedge refClk);
        chk("clamp", clampOn, 1);
        chk("shut", outEnable, 0);
        overCurrent <= 0;
        enReq <= 0;
        repeat (6) @(posedge refClk);
        enReq <= 1;
        repeat (30) @(posedge refClk);
        chk("enable ignored", outEnable, 0);
        chk("latched", faultFlag, 1);
        // Power cycle: only a fresh reset clears the latch
        rst_n <= 0;
        repeat (10) @(posedge refClk);
        rst_n <= 1;
        repeat (2) @(posedge refClk);
        chk("fault cleared", faultFlag, 0);
        chk("clamp cleared", clampOn, 0);
        on_off(0);
        $display("t_fault done");
    endtask

    // Run limit, then the ordered scenarios
    initial begin
        #200000;
        chk("run time", 0, 1);
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge refClk);
        rst_n <= 1;
        repeat (2) @(posedge refClk);
        t_reset();
        t_enable();
        t_pulse();
        t_warn_irq();
        t_therm();
        t_hot();
        t_soft();
        t_fault();
        wrap_up();
    end
endmodule
